// [bench/ssva_regs_asserts.sv]
// Assertion checker for the second stream attribute bank
`timescale 1ns/1ps
module ssva_regs_chk
(
   // Clock, reset and bus
   input wire        ref_clk,
   input wire        rst,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [15:0] wb_adr_i,
   input wire [3:0]  wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   // Watched contents
   input wire [15:0] horizontal_total,
   input wire [23:0] video_ratio_numerator,
   input wire [6:0]  transfer_unit_length,
   input wire [2:0]  pixels_per_clock
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Request taken, and the two kinds of access built on it
   sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ht_wr; s_take ##0 (wb_we_i && wb_adr_i == 16'h0500 && wb_sel_i[1:0] == 2'h3); endsequence
   sequence s_tu_rd; s_take ##0 (!wb_we_i && wb_adr_i == 16'h0530); endsequence
   property p_ack_once; s_take |=> wb_ack_o ##1 !wb_ack_o; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
   property p_tu_even; transfer_unit_length[0] == 1'b0; endproperty
   a_tu_even: assert property (p_tu_even) else $error("unit length odd");
   property p_ht_wr; s_ht_wr |=> horizontal_total == $past(wb_dat_i[15:0]); endproperty
   a_ht_wr: assert property (p_ht_wr) else $error("line total not written");
   property p_rst_val; $fell(rst) |-> transfer_unit_length == 7'h40 && horizontal_total == 16'h0;
   endproperty
   a_rst_val: assert property (p_rst_val) else $error("bad reset contents");
   property p_tu_rd; s_tu_rd |=> wb_dat_o[31:7] == 25'h0 && wb_dat_o[0] == 1'b0; endproperty
   a_tu_rd: assert property (p_tu_rd) else $error("unit length upper bits set");
   property p_num_hold; !(wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 16'h052C)
      |=> $stable(video_ratio_numerator); endproperty
   a_num_hold: assert property (p_num_hold) else $error("ratio changed by itself");
   property p_ppc; pixels_per_clock inside {3'h0, 3'h1, 3'h2, 3'h4}; endproperty
   a_ppc: assert property (p_ppc) else $error("bad pixels per clock");
endmodule
bind ssva_regs ssva_regs_chk i_ssva_regs_chk (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .horizontal_total,
   .video_ratio_numerator, .transfer_unit_length, .pixels_per_clock);

// [bench/tb_ssva_regs.sv]
// Self-checking bench for the second stream attribute bank
`timescale 1ns/1ps
module tb_ssva_regs;
   reg         ref_clk = 1'b0;
   reg         rst = 1'b1;
   reg         cyc = 1'b0;
   reg         we = 1'b0;
   reg  [15:0] adr = 16'h0000;
   reg  [3:0]  sel = 4'hF;
   reg  [31:0] dat = 32'h00000000;
   reg  [31:0] q;
   wire [31:0] q_o;
   wire        ack;
   wire [15:0] ht;
   wire [2:0]  ppc;
   wire        pwv;
   wire        scm;
   wire [15:0] vt, hr, vr, hs, vs;
   wire [14:0] hw, vw;
   wire [23:0] mn, md;
   wire [7:0]  a0, a1;
   wire [6:0]  tu;
   wire [2:0]  pw;
   wire [1:0]  sp;
   integer     n_errors = 0;
   integer     compares = 0;
   integer     ticks = 0;
   integer     i;
   always #2.5 ref_clk = ~ref_clk;
   // Strobe shares the cycle line; tying them apart gains nothing here
   ssva_regs i_ssva_regs (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q_o),
      .wb_ack_o(ack), .horizontal_total(ht), .vertical_total(vt), .sync_polarity(sp),
      .hsync_width(hw), .vsync_width(vw), .horizontal_resolution(hr),
      .vertical_resolution(vr), .horizontal_start(hs), .vertical_start(vs),
      .attribute_byte_zero(a0), .attribute_byte_one(a1),
      .video_ratio_numerator(mn), .video_ratio_denominator(md), .transfer_unit_length(tu),
      .input_pixel_width(pw), .sync_clock_mode(scm), .pixels_per_clock(ppc),
      .pixel_width_valid(pwv));
   // Register contents as seen on the output ports, zero-extended
   function [31:0] port_val(input integer k);
      port_val = (k == 0) ? ht : (k == 1) ? vt : (k == 2) ? sp : (k == 3) ? hw : (k == 4) ? vw
         : (k == 5) ? hr : (k == 6) ? vr : (k == 7) ? hs : (k == 8) ? vs : (k == 9) ? a0
         : (k == 10) ? a1 : (k == 11) ? mn : (k == 12) ? tu : (k == 13) ? md : pw;
   endfunction
   task test_done;
   begin
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   task chk(input [31:0] g, input [31:0] e);
   begin
      compares = compares + 1;
      if (g !== e)
      begin
         n_errors = n_errors + 1;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   end
   endtask
   // One classic cycle; data taken at the edge that sees ack
   task bus(input w, input [15:0] a, input [31:0] d, input [3:0] s);
   begin
      @(posedge ref_clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      @(posedge ref_clk);
      while (ack !== 1'b1)
         @(posedge ref_clk);
      q = q_o;
      cyc <= 1'b0;
   end
   endtask
   // Readable bits of each register, unit length with bit 0 dropped
   function [31:0] fmask(input integer k);
      fmask = (k == 2) ? 32'h3 : (k == 3 || k == 4) ? 32'h7FFF : (k == 9 || k == 10) ? 32'hFF
         : (k == 11 || k == 13) ? 32'hFFFFFF : (k == 12) ? 32'h7E : (k == 14) ? 32'h7 : 32'hFFFF;
   endfunction
   task t_regs;
   begin
      for (i = 0; i < 15; i = i + 1)
      begin
         bus(1'b0, 16'h0500 + 4 * i, 32'h0, 4'hF);
         chk(q, (i == 12) ? 32'h40 : 32'h0);
         chk(port_val(i), (i == 12) ? 32'h40 : 32'h0);
         bus(1'b1, 16'h0500 + 4 * i, 32'hFFFFFFFF, 4'hF);
         bus(1'b0, 16'h0500 + 4 * i, 32'h0, 4'hF);
         chk(q, fmask(i));
         chk(port_val(i), fmask(i));
      end
      bus(1'b1, 16'h0500, 32'h00001234, 4'h1);
      chk(ht, 16'hFF34);
      bus(1'b1, 16'h053C, 32'hFFFFFFFF, 4'hF);
      bus(1'b0, 16'h053C, 32'h0, 4'hF);
      chk(q, 32'h0);
      $display("register test done");
   end
   endtask
   // Ratio values stay as written once clocking turns asynchronous
   task t_ratio;
   begin
      bus(1'b1, 16'h0524, 32'h1, 4'hF);
      bus(1'b1, 16'h052C, 32'hABCDEF, 4'hF);
      chk(scm, 1'b1);
      bus(1'b1, 16'h0534, 32'h123456, 4'hF);
      bus(1'b1, 16'h0524, 32'h0, 4'hF);
      bus(1'b0, 16'h052C, 32'h0, 4'hF);
      chk(q, 32'hABCDEF);
      chk(mn, 32'hABCDEF);
      chk(scm, 1'b0);
      bus(1'b0, 16'h0534, 32'h0, 4'hF);
      chk(q, 32'h123456);
      $display("ratio test done");
   end
   endtask
   task t_width;
   begin
      for (i = 0; i < 4; i = i + 1)
      begin
         bus(1'b1, 16'h0538, (i == 3) ? 32'h3 : (32'h1 << i), 4'hF);
         bus(1'b1, 16'h0530, 32'h21 + i, 4'hF);
         bus(1'b0, 16'h0530, 32'h0, 4'hF);
         chk(ppc, (i == 3) ? 32'h0 : (32'h1 << i));
         chk(pwv, i != 3);
         chk(q, (32'h21 + i) & 32'h7E);
      end
      $display("width test done");
   end
   endtask
   always @(posedge ref_clk)
   begin
      ticks = ticks + 1;
      if (ticks == 3000)
      begin
         n_errors = n_errors + 1;
         test_done;
      end
   end
   initial
   begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs;
      t_ratio;
      t_width;
      test_done;
   end
endmodule

// [design/ssva_defs.vh]
// Offsets, field positions and reset values of the second stream attribute bank
`ifndef SSVA_DEFS_VH
`define SSVA_DEFS_VH

`define SSVA_OFS_HTOTAL      16'h0500
`define SSVA_OFS_VTOTAL      16'h0504
`define SSVA_OFS_POLARITY    16'h0508
`define SSVA_OFS_HSWIDTH     16'h050C
`define SSVA_OFS_VSWIDTH     16'h0510
`define SSVA_OFS_HRES        16'h0514
`define SSVA_OFS_VRES        16'h0518
`define SSVA_OFS_HSTART      16'h051C
`define SSVA_OFS_VSTART      16'h0520
`define SSVA_OFS_ATTR0       16'h0524
`define SSVA_OFS_ATTR1       16'h0528
`define SSVA_OFS_RATIO_NUM   16'h052C
`define SSVA_OFS_TU_LEN      16'h0530
`define SSVA_OFS_RATIO_DEN   16'h0534
`define SSVA_OFS_PIX_WIDTH   16'h0538

`define SSVA_BIT_HSYNC_POL   0
`define SSVA_BIT_VSYNC_POL   1
`define SSVA_BIT_SYNC_CLK    0
`define SSVA_BIT_INTERLACE   0

`define SSVA_TU_LEN_RESET    7'h40
`define SSVA_PIX_ONE         3'h1
`define SSVA_PIX_TWO         3'h2
`define SSVA_PIX_FOUR        3'h4
`define SSVA_UNMAPPED_DATA   32'h00000000

`endif

// [design/ssva_regs.v]
// Wishbone register bank holding second stream video timing and attributes
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`include "ssva_defs.vh"

module ssva_regs
(
   // Clock and reset
   input  wire        ref_clk,
   input  wire        rst,
   // Wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [15:0] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Timing settings to framing logic
   output reg  [15:0] horizontal_total,
   output reg  [15:0] vertical_total,
   output reg  [1:0]  sync_polarity,
   output reg  [14:0] hsync_width,
   output reg  [14:0] vsync_width,
   output reg  [15:0] horizontal_resolution,
   output reg  [15:0] vertical_resolution,
   output reg  [15:0] horizontal_start,
   output reg  [15:0] vertical_start,
   // Attribute settings
   output reg  [7:0]  attribute_byte_zero,
   output reg  [7:0]  attribute_byte_one,
   output reg  [23:0] video_ratio_numerator,
   output reg  [23:0] video_ratio_denominator,
   output reg  [6:0]  transfer_unit_length,
   output reg  [2:0]  input_pixel_width,
   // Decoded status for framing logic
   output reg         sync_clock_mode,
   output reg  [2:0]  pixels_per_clock,
   output reg         pixel_width_valid
);

   // Byte-lane merge of write data into an old value
   function [31:0] merge_lanes;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0]  sel;
      integer      i;
      begin
         merge_lanes = old_val;
         for (i = 0; i < 4; i = i + 1)
            if (sel[i])
               merge_lanes[i*8 +: 8] = new_val[i*8 +: 8];
      end
   endfunction

   // Pixels per clock from the width code; zero when the code is not legal
   function [2:0] pixel_count;
      input [2:0] code;
      begin
         case (code)
            `SSVA_PIX_ONE:  pixel_count = 3'h1;
            `SSVA_PIX_TWO:  pixel_count = 3'h2;
            `SSVA_PIX_FOUR: pixel_count = 3'h4;
            default:        pixel_count = 3'h0;
         endcase
      end
   endfunction

   // Write strobe for one register; shared by every register process
   function write_hit;
      input        strobe;
      input [15:0] adr;
      input [15:0] ofs;
      begin
         write_hit = strobe & (adr == ofs);
      end
   endfunction

   wire        access;
   wire        wr_en;
   reg  [31:0] rd_val;
   reg  [31:0] wr_val;

   // Single-cycle answer; ack low in the cycle after it so each access acks once
   assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_en  = access & wb_we_i;

   // Read mux; narrow registers zero-extended, unmapped reads zero
   always @*
   begin
      case (wb_adr_i)
         `SSVA_OFS_HTOTAL:    rd_val = {16'h0000, horizontal_total};
         `SSVA_OFS_VTOTAL:    rd_val = {16'h0000, vertical_total};
         `SSVA_OFS_POLARITY:  rd_val = {30'h0, sync_polarity};
         `SSVA_OFS_HSWIDTH:   rd_val = {17'h0, hsync_width};
         `SSVA_OFS_VSWIDTH:   rd_val = {17'h0, vsync_width};
         `SSVA_OFS_HRES:      rd_val = {16'h0000, horizontal_resolution};
         `SSVA_OFS_VRES:      rd_val = {16'h0000, vertical_resolution};
         `SSVA_OFS_HSTART:    rd_val = {16'h0000, horizontal_start};
         `SSVA_OFS_VSTART:    rd_val = {16'h0000, vertical_start};
         `SSVA_OFS_ATTR0:     rd_val = {24'h000000, attribute_byte_zero};
         `SSVA_OFS_ATTR1:     rd_val = {24'h000000, attribute_byte_one};
         `SSVA_OFS_RATIO_NUM: rd_val = {8'h00, video_ratio_numerator};
         `SSVA_OFS_TU_LEN:    rd_val = {25'h0, transfer_unit_length};
         `SSVA_OFS_RATIO_DEN: rd_val = {8'h00, video_ratio_denominator};
         `SSVA_OFS_PIX_WIDTH: rd_val = {29'h0, input_pixel_width};
         default:             rd_val = `SSVA_UNMAPPED_DATA;
      endcase
   end

   // Incoming write merged over the current contents by byte lane
   always @*
   begin
      wr_val = merge_lanes(rd_val, wb_dat_i, wb_sel_i);
   end

   // Bus answer; unmapped addresses ack too, so a stray access never hangs
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= access;
         wb_dat_o <= access ? rd_val : 32'h00000000;
      end
   end

   // Line total in clocks; framing reads it on every line
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         horizontal_total <= 16'h0000;
      end
      else if (write_hit(wr_en, wb_adr_i, `SSVA_OFS_HTOTAL))
      begin
         horizontal_total <= wr_val[15:0];
      end
   end

   // Frame total in lines
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         vertical_total <= 16'h0000;
      end
      else if (write_hit(wr_en, wb_adr_i, `SSVA_OFS_VTOTAL))
      begin
         vertical_total <= wr_val[15:0];
      end
   end

   // Sync polarities, vertical in bit 1 and horizontal in bit 0
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         sync_polarity <= 2'h0;
      end
      else if (write_hit(wr_en, wb_adr_i, `SSVA_OFS_POLARITY))
      begin
         sync_polarity <= wr_val[1:0];
      end
   end

   // Horizontal sync width in clocks; bit 15 has no storage
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         hsync_width <= 15'h0;
      end
      else if (write_hit(wr_en, wb_adr_i, `SSVA_OFS_HSWIDTH))
      begin
         hsync_width <= wr_val[14:0];
      end
   end

   // Vertical sync width in lines
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         vsync_width <= 15'h0;
      end
      else if (write_hit(wr_en, wb_adr_i, `SSVA_OFS_VSWIDTH))
      begin
         vsync_width <= wr_val[14:0];
      end
   end

   // Active pixels per line
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         horizontal_resolution <= 16'h0000;
      end
      else if (write_hit(wr_en, wb_adr_i, `SSVA_OFS_HRES))
      begin
         horizontal_resolution <= wr_val[15:0];
      end
   end

   // Active lines per frame
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         vertical_resolution <= 16'h0000;
      end
      else if (write_hit(wr_en, wb_adr_i, `SSVA_OFS_VRES))
      begin
         vertical_resolution <= wr_val[15:0];
      end
   end

   // Clocks from horizontal sync edge to first active pixel
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         horizontal_start <= 16'h0000;
      end
      else if (write_hit(wr_en, wb_adr_i, `SSVA_OFS_HSTART))
      begin
         horizontal_start <= wr_val[15:0];
      end
   end

   // Lines from vertical sync edge to first active line
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         vertical_start <= 16'h0000;
      end
      else if (write_hit(wr_en, wb_adr_i, `SSVA_OFS_VSTART))
      begin
         vertical_start <= wr_val[15:0];
      end
   end

   // First attribute byte; bit 0 picks synchronous clocking
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         attribute_byte_zero <= 8'h00;
      end
      else if (write_hit(wr_en, wb_adr_i, `SSVA_OFS_ATTR0))
      begin
         attribute_byte_zero <= wr_val[7:0];
      end
   end

   // Second attribute byte; bit 7 and reserved bits 6:3 stored as written
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         attribute_byte_one <= 8'h00;
      end
      else if (write_hit(wr_en, wb_adr_i, `SSVA_OFS_ATTR1))
      begin
         attribute_byte_one <= wr_val[7:0];
      end
   end

   // Ratio numerator; only software writes it, async ratio lives elsewhere
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         video_ratio_numerator <= 24'h000000;
      end
      else if (write_hit(wr_en, wb_adr_i, `SSVA_OFS_RATIO_NUM))
      begin
         video_ratio_numerator <= wr_val[23:0];
      end
   end

   // Unit length; bit 0 held low so it stays even, range left to software
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         transfer_unit_length <= `SSVA_TU_LEN_RESET;
      end
      else if (write_hit(wr_en, wb_adr_i, `SSVA_OFS_TU_LEN))
      begin
         transfer_unit_length <= {wr_val[6:1], 1'b0};
      end
   end

   // Ratio denominator; hardware never overwrites it, so readback is exact
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         video_ratio_denominator <= 24'h000000;
      end
      else if (write_hit(wr_en, wb_adr_i, `SSVA_OFS_RATIO_DEN))
      begin
         video_ratio_denominator <= wr_val[23:0];
      end
   end

   // Pixel width code; illegal codes kept so software reads back its value
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         input_pixel_width <= 3'h0;
      end
      else if (write_hit(wr_en, wb_adr_i, `SSVA_OFS_PIX_WIDTH))
      begin
         input_pixel_width <= wr_val[2:0];
      end
   end

   // Decoded views for the framing logic, registered so outputs come from flops
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         sync_clock_mode   <= 1'b0;
         pixels_per_clock  <= 3'h0;
         pixel_width_valid <= 1'b0;
      end
      else
      begin
         sync_clock_mode   <= attribute_byte_zero[`SSVA_BIT_SYNC_CLK];
         pixels_per_clock  <= pixel_count(input_pixel_width);
         pixel_width_valid <= |pixel_count(input_pixel_width);
      end
   end

endmodule
